// ==== design/dma_channel_address_status_regs.sv ====
// DMA channel address, count and controller status registers, AHB-Lite slave
//
// Behaviour
// - Each channel holds a 16-bit secondary buffer start address.
// - Reading secondary start address returns the current working address.
// - Each channel holds a writable 16-bit peripheral address, reset zero.
// - 10-bit count, count plus one transfers per block, upper bits zero.
// - Peripheral write collision flags per channel in bits 15 to 8.
// - DMA RAM write collision flags per channel in bits 7 to 0.
// - Collision flags reset to zero, readable, and clearable by software.
// - Last-channel field resets all ones, then holds last active channel.
// - Ping-pong status bit is 1 for secondary buffer, 0 for primary.
// - Last DMA RAM address holds most recent channel access, resets zero.
// - Any collision raises one shared nonmaskable error trap.
// - Ping-pong alternates buffers; one-shot ping-pong does one of each.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dma_channel_address_status_regs
    import dma_status_pkg::*;
#(
    parameter int NCH = NUM_CH
) (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    nrst,
    // AHB-Lite slave
    input  wire logic                    hsel,
    input  wire logic [7:0]              haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // Transfer engine events (same clock)
    input  wire logic                    xferValid,
    input  wire logic [CH_W-1:0]         xferChannel,
    input  wire logic [ADDR_W-1:0]       xferRamAddr,
    input  wire logic                    blockDone,
    input  wire logic [CH_W-1:0]         blockChannel,
    input  wire logic [NCH-1:0]          periphCollision,
    input  wire logic [NCH-1:0]          ramCollision,
    // Channel controls toward the transfer engine
    output logic      [NCH-1:0]          channelEnable,
    output logic      [NCH-1:0]          pingpongSelect,
    output logic                         errorTrap,
    output logic                         irq
);

    // Decoded bus write or read, taken from the address phase
    logic                 wrPend_q;
    logic                 rdPend_q;
    logic [7:0]           addr_q;
    logic                 accept;

    logic [ADDR_W-1:0]    startB_q   [NCH];
    logic [ADDR_W-1:0]    workAddr_q [NCH];
    logic [ADDR_W-1:0]    periph_q   [NCH];
    logic [CNT_W-1:0]     count_q    [NCH];
    logic [1:0]           mode_q     [NCH];
    logic [NCH-1:0]       enable_q;
    logic [NCH-1:0]       pp_q;
    logic [NCH-1:0]       ppMode;
    logic [NCH-1:0]       pcol_q;
    logic [NCH-1:0]       xcol_q;
    logic [LAST_W-1:0]    last_q;
    logic [ADDR_W-1:0]    lastAddr_q;
    logic [IRQ_W-1:0]     irqStat_q;
    logic [IRQ_W-1:0]     irqMask_q;
    logic [31:0]          rdata_d;

    // Channel index carried in an offset inside the per-channel area
    function automatic logic [CH_W-1:0] chOf(input logic [7:0] a);
        return a[GRP_LSB +: CH_W];
    endfunction

    // Per-channel register write strobe
    function automatic logic chWr(input logic [7:0] a, input logic [7:0] off,
                                  input int ch);
        return a < CH_AREA_END && a[GRP_LSB-1:0] == off[GRP_LSB-1:0]
               && chOf(a) == CH_W'(ch);
    endfunction

    // Block register write strobe
    function automatic logic isAt(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    assign accept = hsel && hready && htrans == HTRANS_NONSEQ;

    // Address phase capture; the slave never stretches a transfer
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q   <= 8'h00;
        end else begin
            wrPend_q <= accept && hwrite && hsize == HSIZE_WORD;
            rdPend_q <= accept && !hwrite;
            if (accept) begin
                addr_q <= haddr;
            end
        end
    end

    // Per-channel programmable registers and working address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int c = 0; c < NCH; c++) begin
                startB_q[c]   <= '0;
                workAddr_q[c] <= '0;
                periph_q[c]   <= '0;
                count_q[c]    <= '0;
                mode_q[c]     <= MODE_CONT;
            end
            enable_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (wrPend_q && chWr(addr_q, OFF_STB, c)) begin
                    startB_q[c]   <= hwdata[ADDR_W-1:0];
                    workAddr_q[c] <= hwdata[ADDR_W-1:0];
                end else if (xferValid && xferChannel == CH_W'(c)) begin
                    workAddr_q[c] <= xferRamAddr;
                end
                if (wrPend_q && chWr(addr_q, OFF_PAD, c)) begin
                    periph_q[c] <= hwdata[ADDR_W-1:0];
                end
                if (wrPend_q && chWr(addr_q, OFF_CNT, c)) begin
                    count_q[c] <= hwdata[CNT_W-1:0];
                end
                if (wrPend_q && chWr(addr_q, OFF_CTL, c)) begin
                    mode_q[c]   <= hwdata[CTL_MODE_LSB +: 2];
                    enable_q[c] <= hwdata[CTL_EN_BIT];
                end else if (blockDone && blockChannel == CH_W'(c)
                             && mode_q[c] == MODE_PP_ONE && pp_q[c]) begin
                    enable_q[c] <= 1'b0;
                end else if (blockDone && blockChannel == CH_W'(c)
                             && mode_q[c] == MODE_ONESHOT) begin
                    enable_q[c] <= 1'b0;
                end
            end
        end
    end

    // Channels whose mode field selects one of the two ping-pong modes
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            ppMode[c] = mode_q[c] == MODE_PP_CONT || mode_q[c] == MODE_PP_ONE;
        end
    end

    // Ping-pong buffer select; forced to primary outside ping-pong modes
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pp_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (!ppMode[c]) begin
                    pp_q[c] <= 1'b0;
                end else if (blockDone && blockChannel == CH_W'(c)) begin
                    pp_q[c] <= !pp_q[c];
                end
            end
        end
    end

    // Collision flags; a new event wins over a same-cycle write-one clear
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pcol_q <= '0;
            xcol_q <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (periphCollision[c]) begin
                    pcol_q[c] <= 1'b1;
                end else if (wrPend_q && isAt(addr_q, OFF_COLL)
                             && hwdata[PCOL_LSB + c]) begin
                    pcol_q[c] <= 1'b0;
                end
                if (ramCollision[c]) begin
                    xcol_q[c] <= 1'b1;
                end else if (wrPend_q && isAt(addr_q, OFF_COLL)
                             && hwdata[c]) begin
                    xcol_q[c] <= 1'b0;
                end
            end
        end
    end

    // Last channel and last DMA RAM address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            last_q     <= LAST_NONE;
            lastAddr_q <= '0;
        end else if (xferValid) begin
            last_q     <= LAST_W'(xferChannel);
            lastAddr_q <= xferRamAddr;
        end
    end

    // Interrupt status, write-one-to-clear, set wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irqStat_q <= '0;
            irqMask_q <= '0;
        end else begin
            for (int b = 0; b < IRQ_W; b++) begin
                if ((b == IRQ_PCOL && |periphCollision)
                    || (b == IRQ_XCOL && |ramCollision)
                    || (b == IRQ_BLOCK && blockDone)) begin
                    irqStat_q[b] <= 1'b1;
                end else if (wrPend_q && isAt(addr_q, OFF_IRQSTAT)
                             && hwdata[b]) begin
                    irqStat_q[b] <= 1'b0;
                end
            end
            if (wrPend_q && isAt(addr_q, OFF_IRQMASK)) begin
                irqMask_q <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // Read mux from the address phase; unmapped reads give zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        if (haddr < CH_AREA_END) begin
            unique case (haddr[GRP_LSB-1:0])
                OFF_STB[GRP_LSB-1:0]: rdata_d[ADDR_W-1:0] =
                    workAddr_q[chOf(haddr)];
                OFF_PAD[GRP_LSB-1:0]: rdata_d[ADDR_W-1:0] =
                    periph_q[chOf(haddr)];
                OFF_CNT[GRP_LSB-1:0]: rdata_d[CNT_W-1:0] =
                    count_q[chOf(haddr)];
                OFF_CTL[GRP_LSB-1:0]: begin
                    rdata_d[CTL_MODE_LSB +: 2] = mode_q[chOf(haddr)];
                    rdata_d[CTL_EN_BIT]        = enable_q[chOf(haddr)];
                end
                default: rdata_d = 32'h0000_0000;
            endcase
        end else if (isAt(haddr, OFF_COLL)) begin
            rdata_d[PCOL_LSB +: NCH] = pcol_q;
            rdata_d[NCH-1:0]         = xcol_q;
        end else if (isAt(haddr, OFF_ACT)) begin
            rdata_d[LAST_LSB +: LAST_W] = last_q;
            rdata_d[NCH-1:0]            = pp_q;
        end else if (isAt(haddr, OFF_LASTADR)) begin
            rdata_d[ADDR_W-1:0] = lastAddr_q;
        end else if (isAt(haddr, OFF_IRQSTAT)) begin
            rdata_d[IRQ_W-1:0] = irqStat_q;
        end else if (isAt(haddr, OFF_IRQMASK)) begin
            rdata_d[IRQ_W-1:0] = irqMask_q;
        end
    end

    // Outputs all registered; read data lands with the data phase
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hrdata         <= 32'h0000_0000;
            hreadyout      <= 1'b1;
            hresp          <= 1'b0;
            channelEnable  <= '0;
            pingpongSelect <= '0;
            errorTrap      <= 1'b0;
            irq            <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (accept && !hwrite) begin
                hrdata <= rdata_d;
            end
            channelEnable  <= enable_q;
            pingpongSelect <= pp_q;
            errorTrap      <= |periphCollision || |ramCollision;
            irq            <= |(irqStat_q & irqMask_q);
        end
    end

    // Checks all run on the one clock and rest while reset is low
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // A collision flag comes up one edge after its event, on any channel
    a_pcol_sets: assert property (
        periphCollision != '0
        |=> (pcol_q & $past(periphCollision)) == $past(periphCollision))
        else $error("peripheral collision flag not set");
    a_xcol_sets: assert property (
        ramCollision != '0
        |=> (xcol_q & $past(ramCollision)) == $past(ramCollision))
        else $error("ram collision flag not set");
    a_flag_sticky: assert property (
        !(wrPend_q && isAt(addr_q, OFF_COLL))
        |=> ({pcol_q, xcol_q} & $past({pcol_q, xcol_q}))
            == $past({pcol_q, xcol_q}))
        else $error("collision flag dropped without clear");
    a_trap_follows: assert property (
        (|periphCollision || |ramCollision) |=> errorTrap)
        else $error("error trap missing after collision");
    a_last_channel: assert property (
        xferValid |=> last_q == LAST_W'($past(xferChannel)))
        else $error("last channel not captured");
    a_last_address: assert property (
        xferValid |=> lastAddr_q == $past(xferRamAddr))
        else $error("last ram address not captured");
    a_pp_zero: assert property (
        ppMode != '1 |=> (pp_q & ~$past(ppMode)) == '0)
        else $error("ping-pong status set outside ping-pong mode");
    a_pp_toggle: assert property (
        blockDone && ppMode[blockChannel]
        |=> pp_q[$past(blockChannel)] != $past(pp_q[blockChannel]))
        else $error("ping-pong select did not toggle");
    a_cnt_upper: assert property (
        accept && !hwrite && haddr < CH_AREA_END
        && haddr[GRP_LSB-1:0] == OFF_CNT[GRP_LSB-1:0]
        |=> hrdata[31:CNT_W] == '0)
        else $error("count upper bits not zero");

endmodule

// ==== dv/dma_channel_address_status_regs_bench.sv ====
// Self-checking bench for the DMA channel address and status registers
`timescale 1ns/1ps
module dma_channel_address_status_regs_bench
    import dma_status_pkg::*;
;
    typedef struct packed {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } row_t;
    logic              ref_clk = 1'b0;
    logic              nrst = 1'b0;
    logic              hsel = 1'b0;
    logic [7:0]        haddr = '0;
    logic [1:0]        htrans = '0;
    logic              hwrite = 1'b0;
    logic [2:0]        hsize = HSIZE_WORD;
    logic [31:0]       hwdata = '0;
    wire  logic        hready;
    logic [31:0]       hrdata;
    logic              hreadyout, hresp, xferValid, blockDone;
    logic [CH_W-1:0]   xferChannel, blockChannel, reqCh = '0;
    logic [ADDR_W-1:0] xferRamAddr, reqAddr = '0;
    logic [NUM_CH-1:0] periphCollision, ramCollision, channelEnable;
    logic [NUM_CH-1:0] pingpongSelect, reqPcol = '0, reqRcol = '0;
    logic              errorTrap, irq, reqXfer = 1'b0, reqDone = 1'b0;
    logic              trapSeen;
    logic [31:0]       q;
    int                failCount = 0, nTests = 0, cycles = 0;
    row_t              rows [6];
    // One slave on the bus, so its ready is the bus ready
    assign hready = hreadyout;
    always #20 ref_clk = ~ref_clk;
    dma_channel_address_status_regs DUT (.ref_clk(ref_clk), .nrst(nrst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .xferValid(xferValid), .xferChannel(xferChannel),
        .xferRamAddr(xferRamAddr), .blockDone(blockDone),
        .blockChannel(blockChannel), .periphCollision(periphCollision),
        .ramCollision(ramCollision), .channelEnable(channelEnable),
        .pingpongSelect(pingpongSelect), .errorTrap(errorTrap), .irq(irq));
    engine_model PARTNER (.ref_clk(ref_clk), .nrst(nrst), .reqXfer(reqXfer),
        .reqCh(reqCh), .reqAddr(reqAddr), .reqDone(reqDone),
        .reqPcol(reqPcol), .reqRcol(reqRcol), .channelEnable(channelEnable),
        .xferValid(xferValid), .xferChannel(xferChannel),
        .xferRamAddr(xferRamAddr), .blockDone(blockDone),
        .blockChannel(blockChannel), .periphCollision(periphCollision),
        .ramCollision(ramCollision));
    // Verdict and end of run, reached from the main sequence or the timeout
    task automatic summarize();
        $display("checks %0d, mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] ra(input int ch, input logic [7:0] off);
        return 8'(ch << GRP_LSB) | off;
    endfunction
    // Single AHB-Lite transfer; entered and left just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        r = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    // One-cycle engine request, trap sampled the cycle after the pulse
    task automatic ev(input logic x, input logic [2:0] c, input logic [15:0] a,
                      input logic dn, input logic [7:0] p,
                      input logic [7:0] r);
        reqXfer <= x;
        reqCh   <= c;
        reqAddr <= a;
        reqDone <= dn;
        reqPcol <= p;
        reqRcol <= r;
        @(posedge ref_clk);
        reqXfer <= 1'b0;
        reqDone <= 1'b0;
        reqPcol <= '0;
        reqRcol <= '0;
        @(posedge ref_clk);
        #1 trapSeen = errorTrap;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        // Bus idle and ready, event outputs quiet, while reset is held
        check(hrdata, 32'h0);
        check({28'h0, hreadyout, hresp, irq, errorTrap}, 32'h8);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus(1'b0, OFF_ACT, 32'h0, q);
        check(q, {20'h0, LAST_NONE, 8'h00});
        bus(1'b0, OFF_COLL, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, OFF_LASTADR, 32'h0, q);
        check(q, 32'h0);
        bus(1'b0, ra(3, OFF_PAD), 32'h0, q);
        check(q, 32'h0);
        $display("test reset done");
    endtask
    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failCount++;
            summarize();
        end
    end
    initial begin
        rows[0] = '{OFF_ACT, 32'h0000ffff, 32'h00000f00};
        rows[1] = '{OFF_LASTADR, 32'h0000ffff, 32'h0};
        rows[2] = '{ra(0, OFF_STB), 32'h0000a5a5, 32'h0000a5a5};
        rows[3] = '{ra(3, OFF_PAD), 32'h0000beef, 32'h0000beef};
        rows[4] = '{ra(7, OFF_CNT), 32'h0000ffff, 32'h000003ff};
        rows[5] = '{8'h94, 32'h0000ffff, 32'h0};
        do_reset();
        // Read-only places and the unmapped word keep their values; STB, PAD and CNT take the write, CNT cut to 10 bits
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].w, q);
            bus(1'b0, rows[i].a, 32'h0, q);
            check(q, rows[i].e);
        end
        // A write narrower than a word is refused and leaves the register
        hsize <= 3'h0;
        bus(1'b1, ra(3, OFF_PAD), 32'h00001111, q);
        hsize <= HSIZE_WORD;
        bus(1'b0, ra(3, OFF_PAD), 32'h0, q);
        check(q, 32'h0000beef);
        $display("test table done");
        // Continuous channel: working address and last-transfer tracking
        bus(1'b1, ra(5, OFF_CTL), 32'h4, q);
        repeat (2) @(posedge ref_clk);
        ev(1'b1, 3'd5, 16'h1234, 1'b0, 8'h0, 8'h0);
        ev(1'b0, 3'd5, 16'h0, 1'b1, 8'h0, 8'h0);
        bus(1'b0, ra(5, OFF_STB), 32'h0, q);
        check(q, 32'h00001234);
        bus(1'b0, OFF_LASTADR, 32'h0, q);
        check(q, 32'h00001234);
        bus(1'b0, OFF_ACT, 32'h0, q);
        check(q, 32'h00000500);
        $display("test transfer done");
        // One-shot ping-pong: one block per buffer, then it stops
        bus(1'b1, ra(1, OFF_CTL), {29'h0, 1'b1, MODE_PP_ONE}, q);
        repeat (2) @(posedge ref_clk);
        ev(1'b0, 3'd1, 16'h0, 1'b1, 8'h0, 8'h0);
        bus(1'b0, OFF_ACT, 32'h0, q);
        check(q, 32'h00000502);
        check({24'h0, channelEnable & pingpongSelect}, 32'h2);
        ev(1'b0, 3'd1, 16'h0, 1'b1, 8'h0, 8'h0);
        bus(1'b0, OFF_ACT, 32'h0, q);
        check(q, 32'h00000500);
        check({31'h0, channelEnable[1]}, 32'h0);
        $display("test pingpong done");
        // Collisions: shared trap, sticky flags, interrupt mask and clear
        ev(1'b0, 3'd0, 16'h0, 1'b0, 8'h80, 8'h01);
        check({31'h0, trapSeen}, 32'h1);
        bus(1'b0, OFF_COLL, 32'h0, q);
        check(q, 32'h00008001);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, OFF_IRQMASK, 32'h3, q);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h1);
        bus(1'b1, OFF_IRQMASK, 32'h0, q);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, OFF_IRQMASK, 32'h3, q);
        bus(1'b1, OFF_IRQSTAT, 32'h3, q);
        repeat (2) @(posedge ref_clk);
        check({31'h0, irq}, 32'h0);
        bus(1'b1, OFF_COLL, 32'h00008000, q);
        bus(1'b0, OFF_COLL, 32'h0, q);
        check(q, 32'h00000001);
        $display("test collision done");
        // Second reset in mid-run restores every status value
        do_reset();
        summarize();
    end
endmodule

// ==== dv/engine_model.sv ====
// Transfer engine model: turns bench requests into one-cycle event pulses
`timescale 1ns/1ps
module engine_model
    import dma_status_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    // Requests from the bench
    input  wire logic              reqXfer,
    input  wire logic [CH_W-1:0]   reqCh,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic              reqDone,
    input  wire logic [NUM_CH-1:0] reqPcol,
    input  wire logic [NUM_CH-1:0] reqRcol,
    input  wire logic [NUM_CH-1:0] channelEnable,
    // Event pulses toward the register block
    output logic                   xferValid,
    output logic      [CH_W-1:0]   xferChannel,
    output logic      [ADDR_W-1:0] xferRamAddr,
    output logic                   blockDone,
    output logic      [CH_W-1:0]   blockChannel,
    output logic      [NUM_CH-1:0] periphCollision,
    output logic      [NUM_CH-1:0] ramCollision
);
    // A disabled channel moves nothing, so its transfer and block-done requests are dropped here; collision requests pass
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            xferValid       <= 1'b0;
            xferChannel     <= '0;
            xferRamAddr     <= '0;
            blockDone       <= 1'b0;
            blockChannel    <= '0;
            periphCollision <= '0;
            ramCollision    <= '0;
        end else begin
            xferValid       <= reqXfer & channelEnable[reqCh];
            xferChannel     <= reqCh;
            // Not held between transfers, so a stale address never passes
            xferRamAddr     <= reqXfer ? reqAddr : ~xferRamAddr;
            blockDone       <= reqDone & channelEnable[reqCh];
            blockChannel    <= reqCh;
            periphCollision <= reqPcol;
            ramCollision    <= reqRcol;
        end
    end
endmodule

// ==== shared/dma_status_pkg.sv ====
// Register map, field layout and reset values of the DMA channel status block
package dma_status_pkg;
    localparam int          NUM_CH        = 8;
    localparam int          ADDR_W        = 16;
    localparam int          CNT_W         = 10;
    localparam int          CH_W          = 3;
    localparam int          LAST_W        = 4;
    // Byte offsets within the block (per-channel group is 16 bytes apart)
    localparam logic [7:0]  OFF_STB       = 8'h00;
    localparam logic [7:0]  OFF_PAD       = 8'h04;
    localparam logic [7:0]  OFF_CNT       = 8'h08;
    localparam logic [7:0]  OFF_CTL       = 8'h0c;
    localparam logic [7:0]  OFF_COLL      = 8'h80;
    localparam logic [7:0]  OFF_ACT       = 8'h84;
    localparam logic [7:0]  OFF_LASTADR   = 8'h88;
    localparam logic [7:0]  OFF_IRQSTAT   = 8'h8c;
    localparam logic [7:0]  OFF_IRQMASK   = 8'h90;
    localparam int          GRP_LSB       = 4;
    localparam logic [7:0]  CH_AREA_END   = 8'h80;
    // Field positions
    localparam int          PCOL_LSB      = 8;
    localparam int          LAST_LSB      = 8;
    localparam int          CTL_EN_BIT    = 2;
    localparam int          CTL_MODE_LSB  = 0;
    // Reset values
    localparam logic [3:0]  LAST_NONE     = 4'hf;
    // Mode field encodings
    localparam logic [1:0]  MODE_CONT     = 2'h0;
    localparam logic [1:0]  MODE_ONESHOT  = 2'h1;
    localparam logic [1:0]  MODE_PP_CONT  = 2'h2;
    localparam logic [1:0]  MODE_PP_ONE   = 2'h3;
    // Interrupt status bits
    localparam int          IRQ_PCOL      = 0;
    localparam int          IRQ_XCOL      = 1;
    localparam int          IRQ_BLOCK     = 2;
    localparam int          IRQ_W         = 3;
    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD    = 3'h2;
endpackage
